// ### rtl/tlbm_consts.vh
`ifndef TLBM_CONSTS_VH
`define TLBM_CONSTS_VH
// ==================================================================
// Instruction field positions (bit 31 of the word is the msb)
// ==================================================================
`define TLBM_PRI_MSB 31
`define TLBM_PRI_LSB 26
`define TLBM_L_BIT 21
`define TLBM_RA_MSB 20
`define TLBM_RA_LSB 16
`define TLBM_RB_MSB 15
`define TLBM_RB_LSB 11
`define TLBM_XO_MSB 10
`define TLBM_XO_LSB 1
`define TLBM_RC_BIT 0
// ==================================================================
// Opcodes
// ==================================================================
`define TLBM_OPC_PRIMARY 6'h1f
`define TLBM_XO_INVAL 10'h132
`define TLBM_XO_LOAD_D 10'h3d2
`define TLBM_GPR_ZERO 5'h00
// ==================================================================
// Address layout
// ==================================================================
`define TLBM_PAGE_SHIFT 12
`define TLBM_SEG_MSB 31
`define TLBM_SEG_LSB 28
`define TLBM_RPN_MSB 31
`define TLBM_RPN_LSB 12
`define TLBM_RPA_ATTR_MSB 11
`define TLBM_RPA_ATTR_LSB 4
// ==================================================================
// Hash pointer layout
// ==================================================================
`define TLBM_HASH_VSID_MSB 16
`define TLBM_HASH_VSID_LSB 7
`define TLBM_HASH_PIDX_MSB 21
`define TLBM_HASH_PIDX_LSB 12
`define TLBM_HTAB_ORG_MSB 31
`define TLBM_HTAB_ORG_LSB 16
`define TLBM_PAGE_TABLE_ENTRY_GROUP_PAD 6'h00
// ==================================================================
// Reset values
// ==================================================================
`define TLBM_RPA_RST 32'h0000_0000
`define TLBM_DATA_MISS_ADDRESS_REG_RST 32'h0000_0000
`define TLBM_DATA_MISS_COMPARE_REG_RST 32'h0000_0000
`define TLBM_PTR_RST 32'h0000_0000
`endif

// ### rtl/tlbm_entry_mem.v
`timescale 1ns/10ps
// ==================================================================
// Entry storage: one write port, one registered read port
// ==================================================================
module tlbm_entry_mem #(
   parameter DW = 64,
   parameter AW = 5
) (
   input wire i_clk,
   input wire i_rst_n,
   input wire i_we,
   input wire [AW-1:0] i_waddr,
   input wire [DW-1:0] i_wdata,
   input wire [AW-1:0] i_raddr,
   output reg [DW-1:0] o_rdata
);
   reg [DW-1:0] mem [0:(1<<AW)-1];

   // The array itself has no reset; the valid bits kept outside make
   // stale contents harmless.
   always @(posedge i_clk) begin
      if (i_we) begin
         mem[i_waddr] <= i_wdata;
      end
   end

   // A read of the address being written returns the old word; the
   // caller forwards the new one.
   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_rdata <= {DW{1'b0}};
      end else begin
         o_rdata <= mem[i_raddr];
      end
   end
endmodule // tlbm_entry_mem

// ### rtl/tlbm_top.v
// How it works
// RL1: new invalidate searches TLB using the effective address from RB.
// RL2: invalidate search ignores instruction and data relocate bits.
// RL3: match uses low effective address bits, never segment registers.
// RL4: every matching entry is marked invalid for later translations.
// RL5: page-size bit zero means 4 KB page, one means large page.
// RL6: old invalidate expands address and invalidates it, relocate ignored.
// RL7: old variant address is RA plus RB, or RB alone when RA is 0.
// RL8: old variant with nonzero RA writes the address back into RA.
// RL9: I/O address skips invalidation but keeps the RA write-back.
// RL10: these instructions never update the fixed-point exception register.
// RL11: record bit set makes the instruction an invalid form.
// RL12: translation indexes an entry by address and flags a miss.
// RL13: data miss captures faulting effective address in miss register.
// RL14: data miss loads target entry first word into compare register.
// RL15: software compares compare register against both hashed groups.
// RL16: data entry load writes the entry picked by its source register.
// RL17: data entry load puts compare register into entry high word.
// RL18: real page and miss address merge into entry low word.
// RL19: problem-state attempt raises a privileged-instruction exception.
// RL20: decode primary 31 with extended 306 invalidate, 978 load.
`timescale 1ns/10ps
`include "tlbm_consts.vh"

module tlbm_top #(
   parameter IDX_W = 5
) (
   input wire i_ref_clk,
   input wire i_rst_n,
   input wire i_instr_valid,
   input wire [31:0] i_instr,
   input wire [31:0] i_gpr_a,
   input wire [31:0] i_gpr_b,
   input wire i_legacy_mode,
   input wire i_msr_pr,
   input wire [15:0] i_io_seg_mask,
   input wire i_rpa_we,
   input wire [31:0] i_rpa_wdata,
   input wire [31:0] i_htab_org,
   input wire i_lkp_valid,
   input wire [31:0] i_lkp_ea,
   input wire [31:0] i_lkp_cmp,
   output reg o_done,
   output reg o_priv_exc,
   output reg o_form_exc,
   output reg o_xer_we,
   output reg o_inval_done,
   output reg o_load_done,
   output reg o_wb_valid,
   output reg [4:0] o_wb_gpr,
   output reg [31:0] o_wb_data,
   output reg o_lkp_done,
   output reg o_lkp_hit,
   output reg o_lkp_miss,
   output reg [31:0] o_lkp_real,
   output reg [31:0] o_data_miss_address_reg,
   output reg [31:0] o_data_miss_compare_reg,
   output reg [31:0] o_rpa,
   output reg [31:0] o_primary_group_pointer_ptr,
   output reg [31:0] o_secondary_group_pointer_ptr,
   output reg [(1<<IDX_W)-1:0] o_entry_valid
);
   localparam NUM_ENT = 1 << IDX_W;
   localparam IDX_LSB = `TLBM_PAGE_SHIFT;
   localparam IDX_MSB = `TLBM_PAGE_SHIFT + IDX_W - 1;

   // ===============================================================
   // Decode
   // ===============================================================
   wire [5:0] pri_op = i_instr[`TLBM_PRI_MSB:`TLBM_PRI_LSB];
   wire [9:0] ext_op = i_instr[`TLBM_XO_MSB:`TLBM_XO_LSB];
   wire [4:0] ra_num = i_instr[`TLBM_RA_MSB:`TLBM_RA_LSB];
   wire rec_bit = i_instr[`TLBM_RC_BIT];
   wire large_pg = i_instr[`TLBM_L_BIT];

   // RL20: opcode decode.
   wire is_tlb_op = i_instr_valid && (pri_op == `TLBM_OPC_PRIMARY);
   wire dec_inval = is_tlb_op && (ext_op == `TLBM_XO_INVAL);
   wire dec_load = is_tlb_op && (ext_op == `TLBM_XO_LOAD_D);
   wire dec_any = dec_inval || dec_load;

   // RL11: invalid form check.
   // An invalid form is reported ahead of the privilege check, so a
   // malformed word never reaches the array even in privileged state.
   wire bad_form = dec_any && rec_bit;

   // RL19: privilege check.
   wire bad_priv = dec_any && !rec_bit && i_msr_pr;

   wire go_inval = dec_inval && !rec_bit && !i_msr_pr;
   wire go_load = dec_load && !rec_bit && !i_msr_pr;

   // ===============================================================
   // Effective address
   // ===============================================================
   wire ra_nonzero = (ra_num != `TLBM_GPR_ZERO);
   wire [31:0] legacy_ea;
   wire [31:0] inval_ea;
   wire [3:0] ea_seg;
   wire ea_is_io;

   // RL7: legacy address sum.
   assign legacy_ea = ra_nonzero ? (i_gpr_a + i_gpr_b) : i_gpr_b;

   // RL1: new form takes RB alone.
   assign inval_ea = i_legacy_mode ? legacy_ea : i_gpr_b;

   assign ea_seg = legacy_ea[`TLBM_SEG_MSB:`TLBM_SEG_LSB];

   // RL9: I/O segment test.
   // Only the legacy form knows about I/O segments; the new form always
   // performs its search.
   assign ea_is_io = i_legacy_mode && i_io_seg_mask[ea_seg];

   // RL6: legacy invalidate unless I/O.
   // RL2: relocate bits play no part.
   // The machine state relocate bits are not even brought in here.
   wire do_inval = go_inval && !ea_is_io;

   // RL3: low address bits index.
   // The index is cut straight from the page number bits of the
   // address; no segment register is looked at.
   wire [IDX_W-1:0] inval_idx = inval_ea[IDX_MSB:IDX_LSB];

   // RL16: entry chosen by RB.
   wire [IDX_W-1:0] load_idx = i_gpr_b[IDX_MSB:IDX_LSB];

   // ===============================================================
   // Miss capture and reload registers
   // ===============================================================
   reg [31:0] data_miss_address_reg_q;
   reg [31:0] data_miss_compare_reg_q;
   reg [31:0] rpa_q;
   reg [31:0] data_miss_address_reg_d;
   reg [31:0] data_miss_compare_reg_d;
   wire [31:0] entry_hi;
   wire [31:0] entry_lo;

   // RL17: high word from compare register.
   assign entry_hi = data_miss_compare_reg_q;

   // RL18: merge real page and miss address.
   // Real page number and attributes from the real page register; the
   // low nibble keeps the segment of the faulting address.
   assign entry_lo = {rpa_q[`TLBM_RPN_MSB:`TLBM_RPN_LSB],
                      rpa_q[`TLBM_RPA_ATTR_MSB:`TLBM_RPA_ATTR_LSB],
                      data_miss_address_reg_q[`TLBM_SEG_MSB:`TLBM_SEG_LSB]};

   // ===============================================================
   // Valid bits
   // ===============================================================
   reg [NUM_ENT-1:0] valid_q;
   reg [NUM_ENT-1:0] valid_d;
   integer k;

   always @* begin
      valid_d = valid_q;
      for (k = 0; k < NUM_ENT; k = k + 1) begin
         // RL4: clear every matching entry.
         // RL5: large page clears them all.
         // A large page spans many 4 KB indices, so every entry could
         // belong to it; dropping all is safe, only costs refills.
         if (do_inval && (large_pg || (inval_idx == k[IDX_W-1:0]))) begin
            valid_d[k] = 1'b0;
         end
         if (go_load && (load_idx == k[IDX_W-1:0])) begin
            valid_d[k] = 1'b1;
         end
      end
   end

   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         valid_q <= {NUM_ENT{1'b0}};
      end else begin
         valid_q <= valid_d;
      end
   end

   // ===============================================================
   // Entry array
   // ===============================================================
   wire [63:0] rd_word;
   wire [IDX_W-1:0] lkp_idx = i_lkp_ea[IDX_MSB:IDX_LSB];

   tlbm_entry_mem #(
      .DW(64),
      .AW(IDX_W)
   ) u_mem (
      .i_clk(i_ref_clk),
      .i_rst_n(i_rst_n),
      .i_we(go_load),
      .i_waddr(load_idx),
      .i_wdata({entry_hi, entry_lo}),
      .i_raddr(lkp_idx),
      .o_rdata(rd_word)
   );

   // ===============================================================
   // Translation lookup, stage one
   // ===============================================================
   reg s1_valid_q;
   reg [31:0] s1_ea_q;
   reg [31:0] s1_cmp_q;
   reg [IDX_W-1:0] s1_idx_q;
   reg s1_fwd_q;
   reg [63:0] s1_fwd_word_q;

   // A load to the index being read in the same cycle would otherwise
   // return the old word against a fresh valid bit.
   wire fwd_now = go_load && (load_idx == lkp_idx);

   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s1_valid_q <= 1'b0;
         s1_ea_q <= 32'h0000_0000;
         s1_cmp_q <= 32'h0000_0000;
         s1_idx_q <= {IDX_W{1'b0}};
         s1_fwd_q <= 1'b0;
         s1_fwd_word_q <= 64'h0000_0000_0000_0000;
      end else begin
         s1_valid_q <= i_lkp_valid;
         s1_ea_q <= i_lkp_ea;
         s1_cmp_q <= i_lkp_cmp;
         s1_idx_q <= lkp_idx;
         s1_fwd_q <= fwd_now;
         s1_fwd_word_q <= {entry_hi, entry_lo};
      end
   end

   // ===============================================================
   // Translation lookup, stage two
   // ===============================================================
   wire [63:0] s1_word = s1_fwd_q ? s1_fwd_word_q : rd_word;

   // RL12: entry select and hit test.
   // The valid bit is read live, so an invalidate issued alongside the
   // lookup already turns it into a miss.
   wire s1_hit = valid_q[s1_idx_q] && (s1_word[63:32] == s1_cmp_q);
   wire s1_miss = s1_valid_q && !s1_hit;

   always @* begin
      data_miss_address_reg_d = data_miss_address_reg_q;
      data_miss_compare_reg_d = data_miss_compare_reg_q;
      if (s1_miss) begin
         // RL13: capture faulting address.
         data_miss_address_reg_d = s1_ea_q;
         // RL14: capture target first word.
         data_miss_compare_reg_d = s1_cmp_q;
      end
   end

   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         data_miss_address_reg_q <= `TLBM_DATA_MISS_ADDRESS_REG_RST;
         data_miss_compare_reg_q <= `TLBM_DATA_MISS_COMPARE_REG_RST;
         rpa_q <= `TLBM_RPA_RST;
      end else begin
         data_miss_address_reg_q <= data_miss_address_reg_d;
         data_miss_compare_reg_q <= data_miss_compare_reg_d;
         if (i_rpa_we) begin
            rpa_q <= i_rpa_wdata;
         end
      end
   end

   // ===============================================================
   // Group pointers for the reload handler
   // ===============================================================
   // RL15: pointers for the software search.
   // Both groups are offered; the handler scans them, the hardware only
   // forms the addresses.
   wire [9:0] hash_p = data_miss_compare_reg_q[`TLBM_HASH_VSID_MSB:`TLBM_HASH_VSID_LSB] ^
                       data_miss_address_reg_q[`TLBM_HASH_PIDX_MSB:`TLBM_HASH_PIDX_LSB];
   wire [9:0] hash_s = ~hash_p;
   wire [15:0] htab_hi = i_htab_org[`TLBM_HTAB_ORG_MSB:`TLBM_HTAB_ORG_LSB];

   // ===============================================================
   // Output registers
   // ===============================================================
   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_done <= 1'b0;
         o_priv_exc <= 1'b0;
         o_form_exc <= 1'b0;
         o_xer_we <= 1'b0;
         o_inval_done <= 1'b0;
         o_load_done <= 1'b0;
         o_wb_valid <= 1'b0;
         o_wb_gpr <= 5'h00;
         o_wb_data <= 32'h0000_0000;
      end else begin
         o_done <= dec_any;
         o_priv_exc <= bad_priv;
         o_form_exc <= bad_form;
         // RL10: exception register untouched.
         o_xer_we <= 1'b0;
         o_inval_done <= do_inval;
         o_load_done <= go_load;
         // RL8: write address back to RA.
         // RL9: write-back survives the I/O case.
         o_wb_valid <= go_inval && i_legacy_mode && ra_nonzero;
         if (i_instr_valid) begin
            o_wb_gpr <= ra_num;
            o_wb_data <= legacy_ea;
         end
      end
   end

   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_lkp_done <= 1'b0;
         o_lkp_hit <= 1'b0;
         o_lkp_miss <= 1'b0;
         o_lkp_real <= 32'h0000_0000;
      end else begin
         o_lkp_done <= s1_valid_q;
         o_lkp_hit <= s1_valid_q && s1_hit;
         o_lkp_miss <= s1_miss;
         o_lkp_real <= {s1_word[31:12], s1_ea_q[11:0]};
      end
   end

   // ===============================================================
   // Register copies for the reload handler
   // ===============================================================
   // The miss pair is shown with this edge's capture, while the group
   // pointers are formed from the stored pair and follow one edge later.
   always @(posedge i_ref_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_data_miss_address_reg <= `TLBM_DATA_MISS_ADDRESS_REG_RST;
         o_data_miss_compare_reg <= `TLBM_DATA_MISS_COMPARE_REG_RST;
         o_rpa <= `TLBM_RPA_RST;
         o_primary_group_pointer_ptr <= `TLBM_PTR_RST;
         o_secondary_group_pointer_ptr <= `TLBM_PTR_RST;
         o_entry_valid <= {NUM_ENT{1'b0}};
      end else begin
         o_data_miss_address_reg <= data_miss_address_reg_d;
         o_data_miss_compare_reg <= data_miss_compare_reg_d;
         o_rpa <= rpa_q;
         o_primary_group_pointer_ptr <= {htab_hi, hash_p, `TLBM_PAGE_TABLE_ENTRY_GROUP_PAD};
         o_secondary_group_pointer_ptr <= {htab_hi, hash_s, `TLBM_PAGE_TABLE_ENTRY_GROUP_PAD};
         o_entry_valid <= valid_d;
      end
   end
endmodule // tlbm_top

// ### testbench/tlbm_chk.sv
`timescale 1ns/10ps
module tlbm_chk #(
   parameter IDX_W = 5
) (
   input wire i_ref_clk,
   input wire i_rst_n,
   input wire i_instr_valid,
   input wire [31:0] i_instr,
   input wire [31:0] i_gpr_a,
   input wire [31:0] i_gpr_b,
   input wire i_legacy_mode,
   input wire i_msr_pr,
   input wire i_lkp_valid,
   input wire [31:0] i_lkp_ea,
   input wire [31:0] i_lkp_cmp,
   input wire o_done,
   input wire o_priv_exc,
   input wire o_form_exc,
   input wire o_xer_we,
   input wire o_inval_done,
   input wire o_load_done,
   input wire o_wb_valid,
   input wire [4:0] o_wb_gpr,
   input wire [31:0] o_wb_data,
   input wire o_lkp_done,
   input wire o_lkp_miss,
   input wire [31:0] o_data_miss_address_reg,
   input wire [31:0] o_data_miss_compare_reg,
   input wire [(1<<IDX_W)-1:0] o_entry_valid
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_n);
   wire op = i_instr_valid && i_instr[31:26] == 6'h1f;
   wire inv = op && i_instr[10:1] == 10'h132;
   wire ld = op && i_instr[10:1] == 10'h3d2;
   wire ok = !i_instr[0] && !i_msr_pr;
   wire [4:0] idx = i_gpr_b[16:12];
   wire [4:0] ra = i_instr[20:16];
   wire [31:0] sum = i_gpr_a + i_gpr_b;
   a_xer_never: assert property (!o_xer_we)
      else $error("exception register written");
   a_decode_done: assert property ((inv || ld) |=> o_done)
      else $error("decoded opcode gave no done");
   a_form_refuse: assert property ((inv || ld) && i_instr[0] |=>
      o_form_exc && !o_inval_done && !o_load_done)
      else $error("record bit form not refused");
   a_priv_refuse: assert property ((inv || ld) && !i_instr[0] &&
      i_msr_pr |=> o_priv_exc && !o_inval_done && !o_load_done &&
      !o_wb_valid)
      else $error("problem state not refused");
   a_inval_entry: assert property (inv && ok && !i_legacy_mode &&
      !i_instr[21] |=> o_inval_done && !o_entry_valid[$past(idx)])
      else $error("entry not invalidated");
   a_large_page: assert property (inv && ok && !i_legacy_mode &&
      i_instr[21] |=> o_entry_valid == '0)
      else $error("large page left entries");
   a_old_wback: assert property (inv && ok && i_legacy_mode |=>
      o_wb_valid == ($past(ra) != 5'h00))
      else $error("write-back presence wrong");
   a_old_sum: assert property (inv && ok && i_legacy_mode && ra != 5'h00
      |=> o_wb_gpr == $past(ra) && o_wb_data == $past(sum))
      else $error("write-back value wrong");
   a_load_entry: assert property (ld && ok |=>
      o_load_done && o_entry_valid[$past(idx)])
      else $error("entry not loaded");
   a_lkp_answer: assert property (i_lkp_valid |-> ##2 o_lkp_done)
      else $error("lookup gave no answer");
   a_miss_capture: assert property (o_lkp_miss |->
      o_data_miss_address_reg == $past(i_lkp_ea, 2) && o_data_miss_compare_reg == $past(i_lkp_cmp, 2))
      else $error("miss registers not captured");
   c_inval: cover property (o_inval_done);
   c_load: cover property (o_load_done);
   c_wback: cover property (o_wb_valid);
   c_miss: cover property (o_lkp_miss);
endmodule // tlbm_chk
bind tlbm_top tlbm_chk #(.IDX_W(IDX_W)) u_chk (.i_ref_clk, .i_rst_n,
   .i_instr_valid, .i_instr, .i_gpr_a, .i_gpr_b, .i_legacy_mode, .i_msr_pr,
   .i_lkp_valid, .i_lkp_ea, .i_lkp_cmp, .o_done, .o_priv_exc, .o_form_exc,
   .o_xer_we, .o_inval_done, .o_load_done, .o_wb_valid, .o_wb_gpr,
   .o_wb_data, .o_lkp_done, .o_lkp_miss, .o_data_miss_address_reg, .o_data_miss_compare_reg, .o_entry_valid);

// ### testbench/tlbm_pipe_model.sv
`timescale 1ns/10ps
// ==================================================================
// Pipeline stand-in: register file and instruction issue
// ==================================================================
module tlbm_pipe_model (
   input wire i_ref_clk,
   input wire i_wb_valid,
   input wire [4:0] i_wb_gpr,
   input wire [31:0] i_wb_data,
   output logic o_instr_valid,
   output logic [31:0] o_instr,
   output logic [31:0] o_gpr_a,
   output logic [31:0] o_gpr_b
);
   logic [31:0] gpr [0:31];
   always @(posedge i_ref_clk)
      if (i_wb_valid) gpr[i_wb_gpr] <= i_wb_data;
   task automatic issue(input [9:0] xo, input [4:0] ra, input [4:0] rb,
      input l, input rc);
      @(negedge i_ref_clk);
      o_instr_valid = 1'h1;
      o_instr = {6'h1f, 4'h0, l, ra, rb, xo, rc};
      o_gpr_a = gpr[ra];
      o_gpr_b = gpr[rb];
   endtask
   // Idle operands flip each time so a stale value never looks live.
   task automatic idle();
      @(negedge i_ref_clk);
      o_instr_valid = 1'h0;
      o_instr = ~o_instr;
      o_gpr_a = ~o_gpr_a;
      o_gpr_b = ~o_gpr_b;
   endtask
   initial begin
      o_instr_valid = 1'h0;
      o_instr = 32'h0;
      o_gpr_a = 32'h0;
      o_gpr_b = 32'h0;
   end
endmodule // tlbm_pipe_model

// ### testbench/tlbm_top_tb.sv
`timescale 1ns/10ps
module tlbm_top_tb;
   logic i_ref_clk = 1'h0, i_rst_n = 1'h0, i_legacy_mode, i_msr_pr;
   logic i_rpa_we, i_lkp_valid;
   logic [15:0] i_io_seg_mask;
   logic [31:0] i_rpa_wdata, i_htab_org, i_lkp_ea, i_lkp_cmp;
   logic [31:0] exp_v, rpa_v, ea, cmp, sum;
   logic [4:0] ra;
   wire i_instr_valid, o_done, o_priv_exc, o_form_exc, o_xer_we;
   wire o_inval_done, o_load_done, o_wb_valid, o_lkp_done, o_lkp_hit;
   wire o_lkp_miss;
   wire [4:0] o_wb_gpr;
   wire [31:0] i_instr, i_gpr_a, i_gpr_b, o_wb_data, o_lkp_real, o_data_miss_address_reg;
   wire [31:0] o_data_miss_compare_reg, o_rpa, o_entry_valid, o_primary_group_pointer_ptr, o_secondary_group_pointer_ptr;
   integer errors = 0, num_checks = 0, seed = 32'h0af4, k, r, ld;
   tlbm_top #(.IDX_W(5)) u_dut (.i_ref_clk, .i_rst_n, .i_instr_valid,
      .i_instr, .i_gpr_a, .i_gpr_b, .i_legacy_mode, .i_msr_pr,
      .i_io_seg_mask, .i_rpa_we, .i_rpa_wdata, .i_htab_org, .i_lkp_valid,
      .i_lkp_ea, .i_lkp_cmp, .o_done, .o_priv_exc, .o_form_exc, .o_xer_we,
      .o_inval_done, .o_load_done, .o_wb_valid, .o_wb_gpr, .o_wb_data,
      .o_lkp_done, .o_lkp_hit, .o_lkp_miss, .o_lkp_real, .o_data_miss_address_reg, .o_data_miss_compare_reg,
      .o_rpa, .o_primary_group_pointer_ptr, .o_secondary_group_pointer_ptr, .o_entry_valid);
   tlbm_pipe_model u_p (.i_ref_clk, .i_wb_valid(o_wb_valid),
      .i_wb_gpr(o_wb_gpr), .i_wb_data(o_wb_data),
      .o_instr_valid(i_instr_valid), .o_instr(i_instr),
      .o_gpr_a(i_gpr_a), .o_gpr_b(i_gpr_b));
   always #5 i_ref_clk = ~i_ref_clk;
   // ===============================================================
   // Expectations and checks
   // ===============================================================
   function automatic [31:0] nv(input [31:0] v, input ld, input l,
      input [31:0] a);
      if (ld) nv = v | (32'h1 << a[16:12]);
      else if (l) nv = 32'h0;
      else nv = v & ~(32'h1 << a[16:12]);
   endfunction
   function automatic [31:0] hp(input [31:0] m, input [31:0] c, input s);
      hp = {i_htab_org[31:16], {10{s}} ^ c[16:7] ^ m[21:12], 6'h0};
   endfunction
   task automatic chk(input string what, input [31:0] e, input [31:0] g);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic op(input [9:0] xo, input [4:0] a, input [4:0] b,
      input l, input rc);
      u_p.issue(xo, a, b, l, rc);
      u_p.idle();
      chk("done", xo == 10'h132 || xo == 10'h3d2, o_done);
      chk("xer_we", 32'h0, o_xer_we);
   endtask
   task automatic look(input [31:0] a, input [31:0] c, input hit);
      @(negedge i_ref_clk);
      i_lkp_valid = 1'h1;
      i_lkp_ea = a;
      i_lkp_cmp = c;
      @(negedge i_ref_clk);
      i_lkp_valid = 1'h0;
      @(negedge i_ref_clk);
      chk("lkp_done", 32'h1, o_lkp_done);
      chk("lkp_hit", {hit, !hit}, {o_lkp_hit, o_lkp_miss});
      if (hit) chk("real", {rpa_v[31:12], a[11:0]}, o_lkp_real);
      else chk("data_miss_address_reg", a, o_data_miss_address_reg);
      if (!hit) begin
         chk("data_miss_compare_reg", c, o_data_miss_compare_reg);
         @(negedge i_ref_clk);
         chk("primary_group_pointer", hp(a, c, 1'h0), o_primary_group_pointer_ptr);
         chk("secondary_group_pointer", hp(a, c, 1'h1), o_secondary_group_pointer_ptr);
      end
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #100000;
      errors++;
      $display("ERROR watchdog expected finish seen hang");
      summarize();
   end
   initial begin
      {i_legacy_mode, i_msr_pr, i_rpa_we, i_lkp_valid} = 4'h0;
      i_io_seg_mask = 16'h0;
      i_htab_org = 32'h0123_0000;
      {i_rpa_wdata, i_lkp_ea, i_lkp_cmp, exp_v} = 128'h0;
      for (k = 0; k < 32; k++) u_p.gpr[k] = $random(seed);
      repeat (10) @(posedge i_ref_clk);
      @(negedge i_ref_clk) i_rst_n = 1'h1;
      chk("rst_valid", 32'h0, o_entry_valid);
      chk("rst_data_miss_address_reg", 32'h0, o_data_miss_address_reg);
      rpa_v = $random(seed);
      i_rpa_wdata = rpa_v;
      i_rpa_we = 1'h1;
      @(negedge i_ref_clk) i_rpa_we = 1'h0;
      repeat (2) @(negedge i_ref_clk);
      chk("rpa", rpa_v, o_rpa);
      // Miss, reload, hit, then a compare mismatch on the same entry.
      ea = u_p.gpr[3];
      cmp = $random(seed);
      look(ea, cmp, 1'h0);
      op(10'h3d2, 5'h0, 5'h3, 1'h0, 1'h0);
      exp_v = nv(exp_v, 1'h1, 1'h0, ea);
      chk("valid_ld", exp_v, o_entry_valid);
      look(ea, cmp, 1'h1);
      look(ea, ~cmp, 1'h0);
      // Segment bits differ, so only the low address bits may match.
      u_p.gpr[4] = {~ea[31:28], ea[27:0]};
      op(10'h132, 5'h0, 5'h4, 1'h0, 1'h0);
      exp_v = nv(exp_v, 1'h0, 1'h0, ea);
      chk("valid_inv", exp_v, o_entry_valid);
      look(ea, cmp, 1'h0);
      for (k = 0; k < 40; k++) begin
         r = 1 + {$random(seed)} % 31;
         ld = $random(seed) & 1;
         ea = u_p.gpr[r];
         op(ld ? 10'h3d2 : 10'h132, 5'h0, r[4:0], 1'h0, 1'h0);
         exp_v = nv(exp_v, ld, 1'h0, ea);
         chk("valid_rnd", exp_v, o_entry_valid);
      end
      u_p.issue(10'h132, 5'h0, 5'h5, 1'h0, 1'h0);
      u_p.issue(10'h3d2, 5'h0, 5'h5, 1'h0, 1'h0);
      u_p.idle();
      exp_v = nv(exp_v, 1'h1, 1'h0, u_p.gpr[5]);
      chk("valid_b2b", exp_v, o_entry_valid);
      for (k = 0; k < 4; k++) begin
         i_msr_pr = !k[1] || k[0];
         op(k[0] ? 10'h3d2 : 10'h132, 5'h0, 5'h6, 1'h0, k[1]);
         chk("form", k[1], o_form_exc);
         chk("priv", !k[1], o_priv_exc);
         chk("valid_ref", exp_v, o_entry_valid);
      end
      i_msr_pr = 1'h0;
      op(10'h236, 5'h0, 5'h6, 1'h0, 1'h0);
      chk("valid_oth", exp_v, o_entry_valid);
      i_legacy_mode = 1'h1;
      for (k = 0; k < 3; k++) begin
         ra = (k == 0) ? 5'h6 : (k == 1) ? 5'h9 : 5'h0;
         sum = (ra != 5'h0 ? u_p.gpr[ra] : 32'h0) + u_p.gpr[7];
         u_p.gpr[8] = sum;
         op(10'h3d2, 5'h0, 5'h8, 1'h0, 1'h0);
         exp_v = nv(exp_v, 1'h1, 1'h0, sum);
         i_io_seg_mask = (k == 1) ? 16'hffff : 16'h0;
         op(10'h132, ra, 5'h7, 1'h0, 1'h0);
         chk("wb_valid", ra != 5'h0, o_wb_valid);
         if (ra != 5'h0) chk("wb", {ra, sum}, {o_wb_gpr, o_wb_data});
         chk("inval", k != 1, o_inval_done);
         if (k != 1) exp_v = nv(exp_v, 1'h0, 1'h0, sum);
         chk("valid_old", exp_v, o_entry_valid);
      end
      i_legacy_mode = 1'h0;
      op(10'h132, 5'h0, 5'h1, 1'h1, 1'h0);
      chk("valid_large", 32'h0, o_entry_valid);
      summarize();
   end
endmodule // tlbm_top_tb
